// ---- verilog/srd_reset_distributor.sv ----
// srd_reset_distributor: builds one system reset and hands a copy to each domain
// assumes slaves and the configuration logic drive active-high levels on clk
`timescale 1ns/1ps
module srd_reset_distributor (
  // system clock and reset
  input wire logic clk,
  input wire logic rst,
  // reset sources
  input wire logic [srd_pkg::SRD_NUM_SLAVES-1:0] slaveResetReq,
  input wire logic reconfigDone,
  // receiving domains
  input wire logic [srd_pkg::SRD_NUM_DOMAINS-1:0] domClk,
  // reset outputs
  output logic sysReset,
  output logic [srd_pkg::SRD_NUM_DOMAINS-1:0] domReset,
  output logic sysResetDone
);
  srd_pkg::srd_sources_t src;
  srd_pkg::srd_state_t state_q;
  srd_pkg::srd_state_t state_d;
  logic [3:0] holdCnt_q;
  logic [3:0] holdCnt_d;
  logic sysReset_q;
  logic sysReset_d;
  // one decode of all sources, shared by the outputs and the checks
  logic anySrc;

  // any source demands reset
  function automatic logic srd_any(input srd_pkg::srd_sources_t s);
    srd_any = s.globalReset | (|s.slaveResetReq) | s.reconfigDone;
  endfunction : srd_any

  // gather sources; reconfiguration pulse treated like any other source
  always_comb begin
    src.globalReset = rst;
    src.slaveResetReq = slaveResetReq;
    src.reconfigDone = reconfigDone;
  end

  // a named net lets the checks look back at the decoded sources
  assign anySrc = srd_any(src);

  // sequencer: stretch pulses to the minimum, no regard for bus activity
  always_comb begin
    state_d = state_q;
    holdCnt_d = holdCnt_q;
    sysReset_d = sysReset_q;
    unique case (state_q)
      srd_pkg::SRD_IDLE: begin
        if (srd_any(src)) begin
          state_d = srd_pkg::SRD_HOLD;
          holdCnt_d = 4'h0;
          sysReset_d = 1'b1;
        end
      end
      srd_pkg::SRD_HOLD: begin
        sysReset_d = 1'b1;
        if (holdCnt_q < 4'(srd_pkg::SRD_MIN_PULSE_CYC)) begin
          holdCnt_d = holdCnt_q + 4'h1;
        end
        if (!srd_any(src) && holdCnt_q >= 4'(srd_pkg::SRD_MIN_PULSE_CYC - 1)) begin
          state_d = srd_pkg::SRD_RELEASE;
          sysReset_d = 1'b0;
        end
      end
      srd_pkg::SRD_RELEASE: begin
        if (srd_any(src)) begin
          state_d = srd_pkg::SRD_HOLD;
          holdCnt_d = 4'h0;
          sysReset_d = 1'b1;
        end else begin
          state_d = srd_pkg::SRD_IDLE;
        end
      end
      // the fourth code is unused; fall back into a held reset
      default: begin
        state_d = srd_pkg::SRD_HOLD;
        holdCnt_d = 4'h0;
        sysReset_d = 1'b1;
      end
    endcase
  end

  // registers; rst itself forces the reset on, as a source
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= srd_pkg::SRD_HOLD;
      holdCnt_q <= 4'h0;
      sysReset_q <= 1'b1;
    end else begin
      state_q <= state_d;
      holdCnt_q <= holdCnt_d;
      sysReset_q <= sysReset_d;
    end
  end

  // combine registered pulse with raw sources so assertion is immediate
  assign sysReset = sysReset_q | anySrc;
  assign sysResetDone = !sysReset_q;

  // one conditioner per domain; components hold a defined state meanwhile
  for (genvar i = 0; i < srd_pkg::SRD_NUM_DOMAINS; i++) begin : g_dom
    srd_domain_sync u_sync (
      .domClk(domClk[i]),
      .sysReset(sysReset),
      .domReset(domReset[i])
    );
  end

  // a new slave request shows on the output in the same cycle
  AST_IMMEDIATE: assert property (@(posedge clk) disable iff (rst)
    (|slaveResetReq) |-> sysReset)
    else $error("slave request not passed to reset");

  // reconfiguration reaches the output in the same cycle
  AST_RECONFIG: assert property (@(posedge clk) disable iff (rst)
    reconfigDone |-> sysReset)
    else $error("reconfiguration not passed to reset");

  // the output never rises for less than one full clock period
  AST_MIN_PULSE: assert property (@(posedge clk) disable iff (rst)
    $rose(sysReset) |=> sysReset)
    else $error("reset pulse shorter than one period");

  // the registered pulse only lets go after a quiet cycle
  AST_RELEASE_QUIET: assert property (@(posedge clk) disable iff (rst)
    $fell(sysReset_q) |-> !$past(anySrc))
    else $error("release while source active");

  // the global input leaves the registered reset set behind it
  AST_GLOBAL: assert property (@(posedge clk)
    rst |=> sysReset_q)
    else $error("global reset did not hold system reset");

  // every domain copy is held while the system reset stands
  AST_DOM_HELD: assert property (@(posedge clk) disable iff (rst)
    sysReset |-> (&domReset))
    else $error("domain reset free while system reset held");

  // done only rises on the way out of a held reset
  AST_DONE: assert property (@(posedge clk) disable iff (rst)
    $rose(sysResetDone) |-> $past(state_q) == srd_pkg::SRD_HOLD)
    else $error("done flag without a held reset");

  // with no source and no pending pulse the output is quiet
  AST_IDLE_OFF: assert property (@(posedge clk) disable iff (rst)
    (state_q == srd_pkg::SRD_IDLE && !anySrc) |-> !sysReset)
    else $error("reset asserted with no source");

  // the global input drives the output directly, even in its first cycle
  AST_GLOBAL_OUT: assert property (@(posedge clk)
    rst |-> sysReset)
    else $error("global reset not on the output");

  // any source seen at an edge leaves the registered pulse set
  AST_ANY_OUT: assert property (@(posedge clk) disable iff (rst)
    anySrc |=> sysReset_q)
    else $error("source did not start a registered pulse");

  // a slave request held over an edge keeps the pulse going
  AST_SLAVE_HOLD: assert property (@(posedge clk) disable iff (rst)
    (|slaveResetReq) |=> sysReset_q)
    else $error("slave request did not hold the pulse");

  // reconfiguration held over an edge keeps the pulse going
  AST_RECONFIG_HOLD: assert property (@(posedge clk) disable iff (rst)
    reconfigDone |=> sysReset_q)
    else $error("reconfiguration did not hold the pulse");

  // the hold counter never runs past the minimum pulse length
  AST_HOLD_CNT: assert property (@(posedge clk) disable iff (rst)
    holdCnt_q <= 4'(srd_pkg::SRD_MIN_PULSE_CYC))
    else $error("hold counter out of range");

  // a held pulse with its sources gone ends at the next edge
  AST_HOLD_END: assert property (@(posedge clk) disable iff (rst)
    (state_q == srd_pkg::SRD_HOLD && !anySrc) |=> !sysReset_q)
    else $error("pulse held with no source");

  // the release state returns to idle when nothing asks for reset
  AST_RELEASE_IDLE: assert property (@(posedge clk) disable iff (rst)
    (state_q == srd_pkg::SRD_RELEASE && !anySrc) |=> state_q == srd_pkg::SRD_IDLE)
    else $error("release state did not return to idle");

  // a source arriving during release starts a fresh pulse
  AST_RETRIGGER: assert property (@(posedge clk) disable iff (rst)
    (state_q == srd_pkg::SRD_RELEASE && anySrc) |=> state_q == srd_pkg::SRD_HOLD)
    else $error("source lost during release");

  // idle always means the registered pulse is low
  AST_IDLE_Q: assert property (@(posedge clk) disable iff (rst)
    state_q == srd_pkg::SRD_IDLE |-> !sysReset_q)
    else $error("registered reset high in idle");

  // the hold state always carries the registered pulse
  AST_HOLD_Q: assert property (@(posedge clk) disable iff (rst)
    state_q == srd_pkg::SRD_HOLD |-> sysReset_q)
    else $error("registered reset low while holding");

  // the release state always has the registered pulse down
  AST_RELEASE_Q: assert property (@(posedge clk) disable iff (rst)
    state_q == srd_pkg::SRD_RELEASE |-> !sysReset_q)
    else $error("registered reset high during release");

  // a fresh pulse starts with a cleared hold counter
  AST_CNT_ENTRY: assert property (@(posedge clk) disable iff (rst)
    (state_q == srd_pkg::SRD_IDLE && anySrc) |=> holdCnt_q == 4'h0)
    else $error("hold counter not cleared on entry");

  // the global input parks the sequencer in the hold state
  AST_RST_STATE: assert property (@(posedge clk)
    rst |=> state_q == srd_pkg::SRD_HOLD)
    else $error("global reset did not park the sequencer");
endmodule : srd_reset_distributor

// ---- shared/srd_pkg.sv ----
// srd_pkg: shared types and constants for the system reset distributor
// assumes one 10 MHz system clock; per-domain clocks arrive as plain inputs
package srd_pkg;
  // sizes of the system module
  localparam int SRD_NUM_DOMAINS = 3;
  localparam int SRD_NUM_SLAVES = 4;
  // clock rate and shortest reset pulse, counted in system clock periods
  localparam int SRD_CLK_PERIOD_NS = 100;
  localparam int SRD_MIN_PULSE_NS = 100;
  localparam int SRD_MIN_PULSE_CYC = (SRD_MIN_PULSE_NS + SRD_CLK_PERIOD_NS - 1)
                                     / SRD_CLK_PERIOD_NS;
  // synchroniser depth for each domain release
  localparam int SRD_SYNC_STAGES = 2;
  // reset value of a synchroniser flop: held in reset
  localparam logic SRD_SYNC_RST_VAL = 1'b1;

  // reset sources gathered together
  typedef struct packed {
    logic globalReset;
    logic [SRD_NUM_SLAVES-1:0] slaveResetReq;
    logic reconfigDone;
  } srd_sources_t;

  // sequencer states
  typedef enum logic [1:0] {
    SRD_IDLE,
    SRD_HOLD,
    SRD_RELEASE
  } srd_state_t;
endpackage : srd_pkg

// ---- verilog/srd_domain_sync.sv ----
// srd_domain_sync: reset conditioner for one receiving clock domain
// assumes the domain clock is a plain input sampled by that domain's flops
`timescale 1ns/1ps
module srd_domain_sync (
  // domain clock
  input wire logic domClk,
  // raw system reset, active high
  input wire logic sysReset,
  // conditioned reset for the domain
  output logic domReset
);
  logic [srd_pkg::SRD_SYNC_STAGES-1:0] syncQ;
  logic [srd_pkg::SRD_SYNC_STAGES-1:0] syncD;

  // shift zeros in once the system reset lets go
  always_comb begin
    syncD = {syncQ[srd_pkg::SRD_SYNC_STAGES-2:0], 1'b0};
  end

  // asserts at once, releases after two domain edges
  always_ff @(posedge domClk or posedge sysReset) begin
    if (sysReset) begin
      syncQ <= {srd_pkg::SRD_SYNC_STAGES{srd_pkg::SRD_SYNC_RST_VAL}};
    end else begin
      syncQ <= syncD;
    end
  end

  // only the last stage leaves the module
  assign domReset = syncQ[srd_pkg::SRD_SYNC_STAGES-1];
endmodule : srd_domain_sync

// ---- testbench/srd_partner_model.sv ----
// srd_partner_model: one component per clock domain, each busy on a transfer
// assumes the component counts beats on its own domain clock
`timescale 1ns/1ps
module srd_partner_model (
  // domain clocks and conditioned resets
  input wire logic [2:0] domClk,
  input wire logic [2:0] domReset,
  // beat counts of the running transfers
  output logic [2:0][3:0] beatCount
);
  for (genvar i = 0; i < 3; i++) begin : g_dom
    logic [3:0] beat_q;
    // reset cuts the transfer on whatever beat it has reached
    always_ff @(posedge domClk[i] or posedge domReset[i]) begin
      if (domReset[i]) begin
        beat_q <= 4'h0;
      end else begin
        beat_q <= beat_q + 4'h1;
      end
    end
    assign beatCount[i] = beat_q;
  end
endmodule : srd_partner_model

// ---- testbench/srd_reset_distributor_tb.sv ----
// srd_reset_distributor_tb: self-checking bench for the reset distributor
// assumes the partner model stands for the components in each domain
`timescale 1ns/1ps
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin errCount++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module srd_reset_distributor_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] slaveResetReq = 4'h0;
  logic reconfigDone = 1'b0;
  logic [2:0] domClk = 3'h0;
  logic sysReset;
  logic [2:0] domReset;
  logic sysResetDone;
  logic [2:0][3:0] compCount;
  int errCount = 0;
  int nChecks = 0;
  int cycCount = 0;
  // domain rates unrelated to the system clock
  always #50 clk = ~clk;
  always #31 domClk[0] = ~domClk[0];
  always #73 domClk[1] = ~domClk[1];
  always #117 domClk[2] = ~domClk[2];
  srd_reset_distributor dut_u (.clk(clk), .rst(rst), .slaveResetReq(slaveResetReq),
    .reconfigDone(reconfigDone), .domClk(domClk), .sysReset(sysReset),
    .domReset(domReset), .sysResetDone(sysResetDone));
  srd_partner_model comp_u (.domClk(domClk), .domReset(domReset), .beatCount(compCount));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // one source for one cycle, mid-transfer, then hold and ordered release
  task automatic pulse_src(input logic [5:0] s);
    int n;
    repeat (12) @(negedge clk);
    `CHK(compCount[2] != 4'h0, 1'b1)
    {rst, reconfigDone, slaveResetReq} = s;
    #1 `CHK(sysReset, 1'b1)
    `CHK(domReset, 3'h7)
    `CHK(compCount, 12'h000)
    @(negedge clk);
    {rst, reconfigDone, slaveResetReq} = 6'h00;
    #1 `CHK(sysReset, 1'b1)
    @(negedge clk);
    `CHK(sysReset, 1'b0)
    `CHK(domReset, 3'h7)
    n = 0;
    while (domReset !== 3'h0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    `CHK(domReset, 3'h0)
    `CHK(sysResetDone, 1'b1)
    $display("source %h done", s);
  endtask : pulse_src
  // long request, then a second source while the sequencer is releasing
  task automatic hold_and_retrigger();
    repeat (4) @(negedge clk);
    slaveResetReq = 4'h2;
    repeat (3) @(negedge clk);
    #1 `CHK(sysReset, 1'b1)
    `CHK(domReset, 3'h7)
    slaveResetReq = 4'h0;
    @(negedge clk);
    reconfigDone = 1'b1;
    #1 `CHK(sysReset, 1'b1)
    `CHK(domReset, 3'h7)
    @(negedge clk);
    reconfigDone = 1'b0;
    #1 `CHK(sysReset, 1'b1)
    @(negedge clk);
    `CHK(sysReset, 1'b0)
    while (domReset !== 3'h0 && cycCount < 2900) @(negedge clk);
    `CHK(domReset, 3'h0)
    $display("hold and retrigger done");
  endtask : hold_and_retrigger
  // cut a hung run short
  always @(posedge clk) begin
    cycCount++;
    if (cycCount == 3000) begin
      errCount++;
      tally_and_finish();
    end
  end
  initial begin
    @(posedge clk);
    #1 `CHK(sysReset, 1'b1)
    `CHK(sysResetDone, 1'b0)
    @(negedge clk);
    @(negedge clk);
    rst = 1'b0;
    pulse_src(6'h20);
    for (int i = 0; i < 4; i++) begin
      pulse_src(6'h01 << i);
    end
    pulse_src(6'h10);
    hold_and_retrigger();
    tally_and_finish();
  end
endmodule : srd_reset_distributor_tb
